// *** design/srts_params.svh ***
`ifndef SRTS_PARAMS_SVH
`define SRTS_PARAMS_SVH
// Clock rate
`define SRTS_CLK_MHZ 200
// Timing figures in their own units
`define SRTS_PGM_SUSP_MAX_US 25
`define SRTS_ERS_SUSP_MAX_US 30
`define SRTS_RESET_MIN_NS 50
`define SRTS_DPD_EXIT_US 30
`define SRTS_ARRAY_RECOV_US 30
// Derived cycle counts
`define SRTS_PGM_SUSP_CYC (`SRTS_PGM_SUSP_MAX_US * `SRTS_CLK_MHZ)
`define SRTS_ERS_SUSP_CYC (`SRTS_ERS_SUSP_MAX_US * `SRTS_CLK_MHZ)
`define SRTS_RESET_MIN_CYC ((`SRTS_RESET_MIN_NS * `SRTS_CLK_MHZ + 999) / 1000)
`define SRTS_DPD_EXIT_CYC (`SRTS_DPD_EXIT_US * `SRTS_CLK_MHZ)
`define SRTS_ARRAY_RECOV_CYC (`SRTS_ARRAY_RECOV_US * `SRTS_CLK_MHZ)
// Default busy times for long operations, in cycles
`define SRTS_SSE_CYC 10000000
`define SRTS_ASPP_CYC 20000
`define SRTS_PASSP_CYC 40000
// Operation codes on i_op
`define SRTS_OP_NONE 3'h0
`define SRTS_OP_PROGRAM 3'h1
`define SRTS_OP_SECTOR_ERASE 3'h2
`define SRTS_OP_SUBSECTOR_ERASE 3'h3
`define SRTS_OP_ASP_PROGRAM 3'h4
`define SRTS_OP_PASSWORD_PROGRAM 3'h5
// Command classes on i_cmd_class
`define SRTS_CLS_READ 3'h0
`define SRTS_CLS_ERASE 3'h1
`define SRTS_CLS_WRSR 3'h2
`define SRTS_CLS_WRNVCR 3'h3
`define SRTS_CLS_OTP 3'h4
`define SRTS_CLS_OTHER 3'h5
`endif

// *** design/srts_pkg.sv ***
package srts_pkg;
  typedef enum logic [2:0] {
    SRTS_IDLE = 3'b000,
    SRTS_BUSY = 3'b001,
    SRTS_SUSPENDING = 3'b010,
    SRTS_SUSPENDED = 3'b011,
    SRTS_RECOVER = 3'b100,
    SRTS_DEEP_SLEEP = 3'b101,
    SRTS_WAKING = 3'b110
  } srts_state_t;
  typedef enum logic [1:0] {
    SRTS_KIND_PGM = 2'b00,
    SRTS_KIND_ERS = 2'b01,
    SRTS_KIND_SSE = 2'b10,
    SRTS_KIND_PROT = 2'b11
  } srts_kind_t;
endpackage

// *** design/srts_sync.sv ***
`timescale 1ns/1ps
module srts_sync (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_rst_val,
  // Asynchronous level in, synchronised level out
  input wire logic i_async,
  output logic o_sync
);
  logic stage1;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      stage1 <= 1'b1;
      o_sync <= 1'b1;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
  logic unused_val;
  assign unused_val = i_rst_val;
endmodule

// *** design/srts_sequencer.sv ***
`timescale 1ns/1ps
`include "srts_params.svh"
// Operation
// - Program suspends within 25 us; reads accepted
// - Erase suspends within 30 us; restricted commands
// - Reset pulses of 50 ns reliably reset
// - Subsector erase reset waits subsector erase time
// - Deep sleep reset waits deep sleep exit
// - Protection register reset waits its program time
// - Password program reset waits password time
// - Deep sleep exit needs 30 us
// - Array software reset needs 30 us recovery
module srts_sequencer #(
  parameter int unsigned PGM_SUSP_CYC = `SRTS_PGM_SUSP_CYC,
  parameter int unsigned ERS_SUSP_CYC = `SRTS_ERS_SUSP_CYC,
  parameter int unsigned DPD_EXIT_CYC = `SRTS_DPD_EXIT_CYC,
  parameter int unsigned ARRAY_RECOV_CYC = `SRTS_ARRAY_RECOV_CYC,
  parameter int unsigned SSE_CYC = `SRTS_SSE_CYC,
  parameter int unsigned ASPP_CYC = `SRTS_ASPP_CYC,
  parameter int unsigned PASSP_CYC = `SRTS_PASSP_CYC,
  parameter int unsigned RESET_MIN_CYC = `SRTS_RESET_MIN_CYC
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Pins from the host
  input wire logic i_cs_n,
  input wire logic i_reset_n,
  // Decoded command strobes from the serial front end
  input wire logic i_start,
  input wire logic [2:0] i_op,
  input wire logic i_suspend,
  input wire logic i_resume,
  input wire logic i_op_done,
  input wire logic i_sw_reset,
  input wire logic i_enter_deep,
  input wire logic i_cmd_valid,
  input wire logic [2:0] i_cmd_class,
  // Status
  output logic o_busy,
  output logic o_suspended,
  output logic o_deep_sleep_state,
  output logic o_cmd_accept,
  output logic o_cmd_reject
);
  localparam int CW = 32;
  srts_pkg::srts_state_t state;
  srts_pkg::srts_state_t next_state;
  srts_pkg::srts_kind_t kind;
  srts_pkg::srts_kind_t next_kind;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic [CW-1:0] low_count;
  logic cs_n_s;
  logic reset_n_s;
  logic pin_reset;
  logic any_reset;
  logic armed_cs;
  logic count_zero;
  logic [CW-1:0] recov_cyc;
  logic allowed;
  logic is_restricted;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  srts_sync u_sync_cs (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_rst_val(1'b1),
    .i_async(i_cs_n),
    .o_sync(cs_n_s)
  );
  srts_sync u_sync_rst (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_rst_val(1'b1),
    .i_async(i_reset_n),
    .o_sync(reset_n_s)
  );

  // ----------------------------------------
  // Reset pulse width qualification
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      low_count <= '0;
    end else if (reset_n_s) begin
      low_count <= '0;
    end else if (low_count != RESET_MIN_CYC[CW-1:0]) begin
      low_count <= low_count + 32'h1;
    end
  end
  // Fires on release after a low of at least the minimum width
  assign pin_reset = reset_n_s && (low_count == RESET_MIN_CYC[CW-1:0]);
  assign any_reset = pin_reset || i_sw_reset;

  // Recovery time chosen by what the device was doing
  always_comb begin
    recov_cyc = '0;
    if (state == srts_pkg::SRTS_DEEP_SLEEP || state == srts_pkg::SRTS_WAKING) begin
      recov_cyc = DPD_EXIT_CYC[CW-1:0];
    end else if (state == srts_pkg::SRTS_BUSY || state == srts_pkg::SRTS_SUSPENDING ||
                 state == srts_pkg::SRTS_SUSPENDED) begin
      unique case (kind)
        srts_pkg::SRTS_KIND_SSE: recov_cyc = SSE_CYC[CW-1:0];
        srts_pkg::SRTS_KIND_PROT: recov_cyc = (i_op == `SRTS_OP_PASSWORD_PROGRAM) ?
          PASSP_CYC[CW-1:0] : ASPP_CYC[CW-1:0];
        srts_pkg::SRTS_KIND_PGM,
        srts_pkg::SRTS_KIND_ERS: recov_cyc = ARRAY_RECOV_CYC[CW-1:0];
      endcase
    end
  end

  assign count_zero = (count == '0);
  assign is_restricted = (i_cmd_class == `SRTS_CLS_ERASE) || (i_cmd_class == `SRTS_CLS_WRSR) ||
                         (i_cmd_class == `SRTS_CLS_WRNVCR) || (i_cmd_class == `SRTS_CLS_OTP);
  // Commands accepted in idle; while suspended per operation kind
  assign allowed = (state == srts_pkg::SRTS_IDLE) ||
    ((state == srts_pkg::SRTS_SUSPENDED) &&
     ((kind == srts_pkg::SRTS_KIND_PGM) ? (i_cmd_class == `SRTS_CLS_READ)
                                         : !is_restricted));

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_kind = kind;
    next_count = count_zero ? count : count - 32'h1;
    if (any_reset) begin
      next_state = srts_pkg::SRTS_RECOVER;
      next_count = recov_cyc;
    end else begin
      unique case (state)
        srts_pkg::SRTS_IDLE: begin
          if (i_enter_deep) begin
            next_state = srts_pkg::SRTS_DEEP_SLEEP;
          end else if (i_start && i_op != `SRTS_OP_NONE) begin
            next_state = srts_pkg::SRTS_BUSY;
            unique case (i_op)
              `SRTS_OP_PROGRAM: next_kind = srts_pkg::SRTS_KIND_PGM;
              `SRTS_OP_SECTOR_ERASE: next_kind = srts_pkg::SRTS_KIND_ERS;
              `SRTS_OP_SUBSECTOR_ERASE: next_kind = srts_pkg::SRTS_KIND_SSE;
              default: next_kind = srts_pkg::SRTS_KIND_PROT;
            endcase
          end
        end
        srts_pkg::SRTS_BUSY: begin
          if (i_op_done) begin
            next_state = srts_pkg::SRTS_IDLE;
          end else if (i_suspend && kind != srts_pkg::SRTS_KIND_PROT) begin
            next_state = srts_pkg::SRTS_SUSPENDING;
            // Loaded one short so the flag rises at the limit itself, not one cycle after
            next_count = (kind == srts_pkg::SRTS_KIND_PGM) ? PGM_SUSP_CYC[CW-1:0] - 32'h1
                                                           : ERS_SUSP_CYC[CW-1:0] - 32'h1;
          end
        end
        srts_pkg::SRTS_SUSPENDING: begin
          if (count_zero) begin
            next_state = srts_pkg::SRTS_SUSPENDED;
          end
        end
        srts_pkg::SRTS_SUSPENDED: begin
          if (i_resume) begin
            next_state = srts_pkg::SRTS_BUSY;
          end
        end
        srts_pkg::SRTS_RECOVER: begin
          if (count_zero) begin
            next_state = srts_pkg::SRTS_IDLE;
          end
        end
        srts_pkg::SRTS_DEEP_SLEEP: begin
          if (armed_cs && cs_n_s) begin
            next_state = srts_pkg::SRTS_WAKING;
            next_count = DPD_EXIT_CYC[CW-1:0];
          end
        end
        srts_pkg::SRTS_WAKING: begin
          if (count_zero) begin
            next_state = srts_pkg::SRTS_IDLE;
          end
        end
        default: next_state = srts_pkg::SRTS_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= srts_pkg::SRTS_IDLE;
      kind <= srts_pkg::SRTS_KIND_PGM;
      count <= '0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      count <= next_count;
    end
  end

  // Deep sleep wakes when a select made during it ends; exit time runs from deselect
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      armed_cs <= 1'b0;
    end else if (state != srts_pkg::SRTS_DEEP_SLEEP) begin
      armed_cs <= 1'b0;
    end else if (!cs_n_s) begin
      armed_cs <= 1'b1;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_busy <= 1'b0;
      o_suspended <= 1'b0;
      o_deep_sleep_state <= 1'b0;
    end else begin
      o_busy <= (next_state != srts_pkg::SRTS_IDLE) && (next_state != srts_pkg::SRTS_SUSPENDED)
                && (next_state != srts_pkg::SRTS_DEEP_SLEEP);
      o_suspended <= (next_state == srts_pkg::SRTS_SUSPENDED);
      o_deep_sleep_state <= (next_state == srts_pkg::SRTS_DEEP_SLEEP);
    end
  end
  assign o_cmd_accept = i_cmd_valid && allowed;
  assign o_cmd_reject = i_cmd_valid && !allowed;
endmodule

// *** verif/srts_sequencer_props.sv ***
`timescale 1ns/1ps
module srts_sequencer_props #(
  parameter int unsigned PGM_SUSP_CYC = 20,
  parameter int unsigned ERS_SUSP_CYC = 30,
  parameter int unsigned DPD_EXIT_CYC = 40,
  parameter int unsigned ARRAY_RECOV_CYC = 50
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Requests
  input wire logic i_start,
  input wire logic [2:0] i_op,
  input wire logic i_suspend,
  input wire logic i_sw_reset,
  input wire logic i_cmd_valid,
  input wire logic [2:0] i_cmd_class,
  // Status
  input wire logic o_busy,
  input wire logic o_suspended,
  input wire logic o_deep_sleep_state,
  input wire logic o_cmd_accept,
  input wire logic o_cmd_reject
);
  localparam int PW = PGM_SUSP_CYC + 1;
  localparam int EW = ERS_SUSP_CYC + 1;
  logic [2:0] op;
  logic rec;
  int cnt;
  int exp_c;
  wire logic idle = !o_busy && !o_suspended && !o_deep_sleep_state;
  wire logic pgm = op == 3'h1;
  wire logic ers = op == 3'h2 || op == 3'h3;
  wire logic bad = i_cmd_class inside {[3'h1:3'h4]};
  wire logic arr = (o_busy || o_suspended) && (pgm || op == 3'h2);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  // Recovery length tracked only for deep sleep and program or sector erase
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      op <= 3'h0;
      rec <= 1'b0;
      cnt <= 0;
      exp_c <= 0;
    end else if (i_sw_reset) begin
      rec <= o_deep_sleep_state || arr;
      cnt <= 0;
      exp_c <= o_deep_sleep_state ? DPD_EXIT_CYC : ARRAY_RECOV_CYC;
    end else begin
      op <= (i_start && idle) ? i_op : op;
      cnt <= cnt + 1;
      rec <= rec && cnt <= exp_c + 4;
    end
  end
  AST_PGM_LAT: assert property (i_suspend && o_busy && !o_suspended && pgm |-> ##[1:PW] o_suspended)
    else $error("program suspend too slow");
  AST_PGM_CMD: assert property (o_suspended && pgm && i_cmd_valid |->
    o_cmd_accept == (i_cmd_class == 3'h0)) else $error("program suspended answer");
  AST_ERS_LAT: assert property (i_suspend && o_busy && !o_suspended && ers |-> ##[1:EW] o_suspended)
    else $error("erase suspend too slow");
  AST_ERS_CMD: assert property (o_suspended && ers && i_cmd_valid |-> o_cmd_accept == !bad)
    else $error("erase suspended answer");
  AST_ONE_ANSWER: assert property (i_cmd_valid |-> o_cmd_accept != o_cmd_reject)
    else $error("accept and reject clash");
  AST_DEEP_REJ: assert property (o_deep_sleep_state && i_cmd_valid |-> o_cmd_reject)
    else $error("command taken in deep sleep");
  AST_WAKE_BUSY: assert property ($fell(o_deep_sleep_state) |-> ##1 o_busy [*8])
    else $error("ready too soon after deep sleep");
  AST_RECOV: assert property (rec && $fell(o_busy) |-> cnt + 1 >= exp_c && cnt <= exp_c + 3)
    else $error("recovery length off");
  cover property (o_suspended && pgm);
  cover property (o_suspended && ers);
  cover property (rec && $fell(o_busy));
  cover property ($fell(o_deep_sleep_state));
endmodule
bind srts_sequencer srts_sequencer_props #(.PGM_SUSP_CYC(PGM_SUSP_CYC),
  .ERS_SUSP_CYC(ERS_SUSP_CYC), .DPD_EXIT_CYC(DPD_EXIT_CYC), .ARRAY_RECOV_CYC(ARRAY_RECOV_CYC))
  i_props (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_start(i_start), .i_op(i_op),
  .i_suspend(i_suspend), .i_sw_reset(i_sw_reset), .i_cmd_valid(i_cmd_valid),
  .i_cmd_class(i_cmd_class), .o_busy(o_busy), .o_suspended(o_suspended),
  .o_deep_sleep_state(o_deep_sleep_state), .o_cmd_accept(o_cmd_accept),
  .o_cmd_reject(o_cmd_reject));

// *** verif/srts_host.sv ***
`timescale 1ns/1ps
module srts_host (
  // Clock
  input wire logic i_sys_clk,
  // Pins to the device
  output logic o_cs_n,
  output logic o_reset_n
);
  initial begin
    o_cs_n = 1'b1;
    o_reset_n = 1'b1;
  end
  // Chip select is already high for many cycles when reset is released
  task automatic pin_reset(input int n);
    @(posedge i_sys_clk);
    #1 o_reset_n = 1'b0;
    o_cs_n = 1'b1;
    repeat (n) @(posedge i_sys_clk);
    #1 o_reset_n = 1'b1;
  endtask
  task automatic sel(input logic l);
    @(posedge i_sys_clk);
    #1 o_cs_n = l;
  endtask
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ps
`include "srts_params.svh"
module tb;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [5:0] s = 6'h00;
  logic [2:0] op = 3'h0;
  logic v = 1'b0;
  logic [2:0] cls = 3'h0;
  wire logic cs_n, rst_n, busy, susp, deep, acc, rej;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n;
  always #2.5 i_sys_clk = ~i_sys_clk;
  srts_host i_srts_host (.i_sys_clk(i_sys_clk), .o_cs_n(cs_n), .o_reset_n(rst_n));
  srts_sequencer #(.PGM_SUSP_CYC(20), .ERS_SUSP_CYC(30), .SSE_CYC(60), .ASPP_CYC(30),
    .PASSP_CYC(45)) i_srts_sequencer (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_reset_n(rst_n),
    .i_start(s[0]), .i_op(op), .i_suspend(s[1]), .i_resume(s[2]), .i_op_done(s[3]),
    .i_sw_reset(s[4]), .i_enter_deep(s[5]), .i_cmd_valid(v), .i_cmd_class(cls),
    .o_busy(busy), .o_suspended(susp), .o_deep_sleep_state(deep),
    .o_cmd_accept(acc), .o_cmd_reject(rej));
  task chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task p(input logic [5:0] m);
    @(posedge i_sys_clk);
    #1 s = m;
    @(posedge i_sys_clk);
    #1 s = 6'h00;
  endtask
  // b high waits for suspended, b low waits for not busy
  task till(input logic b);
    n = 0;
    while ((b ? susp : busy) !== b && n < 7000) begin
      @(posedge i_sys_clk);
      #1 n++;
    end
  endtask
  task cmd(input logic [2:0] c, input logic e);
    @(posedge i_sys_clk);
    #1 cls = c;
    v = 1'b1;
    #1 chk(acc === e && rej === !e, "command answer");
    @(posedge i_sys_clk);
    #1 v = 1'b0;
  endtask
  task t_susp(input logic [2:0] o, input int w, input int lim);
    op = o;
    p(6'h01);
    repeat (w) @(posedge i_sys_clk);
    p(6'h02);
    till(1'b1);
    chk(n <= lim, "suspend latency");
    for (int c = 0; c < 6; c++) cmd(c[2:0], o == 3'h1 ? c == 0 : !(c inside {[1:4]}));
    p(6'h04);
    chk(busy === 1'b1 && susp === 1'b0, "resume");
    p(6'h08);
    till(1'b0);
  endtask
  task t_rst(input logic [5:0] m, input logic [2:0] o, input int e);
    op = o;
    p(m);
    p(6'h10);
    till(1'b0);
    chk(n + 3 >= e && n <= e + 2, "recovery length");
  endtask
  task t_wake;
    p(6'h20);
    chk(deep === 1'b1 && busy === 1'b0, "deep sleep");
    cmd(3'h0, 1'b0);
    i_srts_host.sel(1'b0);
    i_srts_host.sel(1'b1);
    repeat (3) @(posedge i_sys_clk);
    #1 chk(busy === 1'b1 && deep === 1'b0, "wake start");
    till(1'b0);
    chk(n >= `SRTS_DPD_EXIT_CYC && n <= `SRTS_DPD_EXIT_CYC + 2, "wake length");
  endtask
  task t_pin;
    op = 3'h1;
    p(6'h01);
    i_srts_host.pin_reset(12);
    till(1'b0);
    chk(n >= `SRTS_ARRAY_RECOV_CYC && n <= `SRTS_ARRAY_RECOV_CYC + 6, "pin reset recovery");
  endtask
  task results;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge i_sys_clk);
    #1 i_rst = 1'b0;
    t_susp(3'h1, 4, 20);
    t_susp(3'h2, 150, 30);
    t_susp(3'h3, 50, 30);
    t_rst(6'h01, 3'h1, `SRTS_ARRAY_RECOV_CYC);
    t_rst(6'h01, 3'h3, 60);
    t_rst(6'h01, 3'h4, 30);
    t_rst(6'h01, 3'h5, 45);
    t_rst(6'h20, 3'h0, `SRTS_DPD_EXIT_CYC);
    t_wake;
    t_pin;
    results();
  end
  initial begin
    #200000;
    n_mismatch++;
    results();
  end
endmodule
